// ===== adio_ctrl_model.sv
// controller side model: measures the speed pulse train
`timescale 1ns/1ps
`default_nettype none
module adio_ctrl_model
   import adio_pkg::*;
(
   input wire logic mclk,
   input wire logic reset,
   input wire logic speedPulseOut,
   output int rpm,
   output int width
);
   int period;
   int hiCnt;
   logic lastPulse;
   // 64-bit math: clock rate times sixty overflows an int
   always_ff @(posedge mclk or posedge reset) begin
      if (reset) begin
         period <= 0;
         hiCnt <= 0;
         lastPulse <= 1'b0;
         rpm <= 0;
         width <= 0;
      end else begin
         lastPulse <= speedPulseOut;
         period <= period + 1;
         if (speedPulseOut) begin
            hiCnt <= hiCnt + 1;
         end
         if (speedPulseOut && !lastPulse) begin
            period <= 1;
            hiCnt <= 1;
            if (period > 0) begin
               rpm <= int'(longint'(CLK_HZ) * 60 / PULSES_PER_REV / period);
            end
         end
         if (!speedPulseOut && lastPulse) begin
            width <= hiCnt;
         end
      end
   end
endmodule : adio_ctrl_model
`default_nettype wire

// ===== adio_logic.sv
// discrete i/o control and status logic of the agitator motor driver
`timescale 1ns/1ps
`default_nettype none
module adio_logic
   import adio_pkg::*;
#(
   parameter int TERMS = 7,
   parameter int SPEED_PULSE_CYC = SPEED_PULSE_CYC_DEF
) (
   input wire logic mclk,
   input wire logic reset,
   // classic wishbone slave
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [7:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   // controller input terminals, asynchronous
   input wire logic [TERMS-1:0] terminalIn,
   // motor drive side, on mclk
   input wire logic rotationTick,
   input wire logic [11:0] measuredSpeed,
   input wire logic [8:0] loadFactor,
   input wire logic overloadAlarm,
   input wire logic protectAlarm,
   input wire logic warningActive,
   output logic motorRun,
   output logic motorReverse,
   output logic instantStop,
   output logic holdRelease,
   output adio_opdata_s activeData,
   // controller output terminals
   output logic speedPulseOut,
   output logic fault_indicator_out,
   output logic overload_indicator_out,
   output logic runningOut,
   output logic speed_reached_out,
   output logic caution_indicator_out
);

   // ---------------------------------------------------------------
   // input synchronisers and terminal function mapping
   // ---------------------------------------------------------------
   logic [TERMS-1:0] termMeta;
   logic [TERMS-1:0] termSync;
   logic [1:0] syncFill;
   logic [FN_BITS*TERMS-1:0] termMap;
   logic [7:0] fnLevel;
   logic [7:0] fnMapped;

   always_ff @(posedge mclk or posedge reset) begin
      if (reset) begin
         termMeta <= '0;
         termSync <= '0;
         syncFill <= '0;
      end else begin
         termMeta <= terminalIn;
         termSync <= termMeta;
         syncFill <= {syncFill[0], 1'b1};
      end
   end

   // the same function on two terminals is simply or-ed
   always_comb begin
      fnLevel = '0;
      fnMapped = '0;
      for (int t = 0; t < TERMS; t++) begin
         fnLevel[termMap[FN_BITS*t +: FN_BITS]] |= termSync[t];
         fnMapped[termMap[FN_BITS*t +: FN_BITS]] = 1'b1;
      end
   end

   logic fwdOn;
   logic revOn;
   logic clearOn;
   logic extOpen;
   logic [1:0] selSet;

   assign fwdOn = fnLevel[FN_FWD];
   assign revOn = fnLevel[FN_REV];
   assign clearOn = fnLevel[FN_CLEAR];
   // unmapped external fault is treated as closed so it cannot trip
   // held off until the synchroniser has filled, else reset reads as an open contact
   assign extOpen = syncFill[1] & fnMapped[FN_EXT_FAULT] & ~fnLevel[FN_EXT_FAULT];
   assign selSet = {fnLevel[FN_SEL_HIGH], fnLevel[FN_SEL_LOW]};

   // ---------------------------------------------------------------
   // configuration registers
   // ---------------------------------------------------------------
   logic holdEnable;
   logic [8:0] speedBand;
   logic [8:0] overloadLevel;
   adio_opdata_s opSet [OPDATA_SETS];
   logic wbWrite;
   logic [31:0] laneMask;
   logic [31:0] bandMerged;
   logic [31:0] levelMerged;
   logic [31:0] mapMerged;

   assign wbWrite = wb_cyc_i & wb_stb_i & wb_we_i & ~wb_ack_o;
   assign laneMask = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}}, {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
   assign bandMerged = ({23'h0, speedBand} & ~laneMask) | (wb_dat_i & laneMask);
   assign levelMerged = ({23'h0, overloadLevel} & ~laneMask) | (wb_dat_i & laneMask);
   assign mapMerged = ({{(32-FN_BITS*TERMS){1'b0}}, termMap} & ~laneMask) | (wb_dat_i & laneMask);

   always_ff @(posedge mclk or posedge reset) begin
      if (reset) begin
         holdEnable <= 1'b0;
      end else if (wbWrite && wb_adr_i == REG_CTRL && wb_sel_i[0]) begin
         holdEnable <= wb_dat_i[CTRL_HOLD_EN_BIT];
      end
   end

   // band writes above the top of the range are clamped
   always_ff @(posedge mclk or posedge reset) begin
      if (reset) begin
         speedBand <= BAND_RST;
      end else if (wbWrite && wb_adr_i == REG_BAND) begin
         if (bandMerged > {23'h0, BAND_MAX}) begin
            speedBand <= BAND_MAX;
         end else begin
            speedBand <= bandMerged[8:0];
         end
      end
   end

   always_ff @(posedge mclk or posedge reset) begin
      if (reset) begin
         overloadLevel <= OVLWARN_RST;
      end else if (wbWrite && wb_adr_i == REG_OVLWARN) begin
         overloadLevel <= levelMerged[8:0];
      end
   end

   always_ff @(posedge mclk or posedge reset) begin
      if (reset) begin
         termMap <= TERMMAP_RST[FN_BITS*TERMS-1:0];
      end else if (wbWrite && wb_adr_i == REG_TERMMAP) begin
         termMap <= mapMerged[FN_BITS*TERMS-1:0];
      end
   end

   always_ff @(posedge mclk or posedge reset) begin
      if (reset) begin
         for (int i = 0; i < OPDATA_SETS; i++) begin
            opSet[i] <= OPDATA_RST;
         end
      end else begin
         for (int i = 0; i < OPDATA_SETS; i++) begin
            if (wbWrite && wb_adr_i == REG_OPDATA0 + 8'(4 * i)) begin
               opSet[i] <= (opSet[i] & ~laneMask[27:0]) | (wb_dat_i[27:0] & laneMask[27:0]);
            end
         end
      end
   end

   // ---------------------------------------------------------------
   // alarm latch
   // ---------------------------------------------------------------
   logic clearPrev;
   logic clearEdge;
   logic alarmLatched;
   adio_alarm_e alarmCode;
   logic alarmSource;

   assign clearEdge = clearOn & ~clearPrev;
   assign alarmSource = extOpen | overloadAlarm | protectAlarm;

   always_ff @(posedge mclk or posedge reset) begin
      if (reset) begin
         clearPrev <= 1'b0;
      end else begin
         clearPrev <= clearOn;
      end
   end

   // a cause still present keeps the alarm: set wins over clear
   always_ff @(posedge mclk or posedge reset) begin
      if (reset) begin
         alarmLatched <= 1'b0;
         alarmCode <= ALM_NONE;
      end else if (alarmSource) begin
         alarmLatched <= 1'b1;
         if (!alarmLatched) begin
            alarmCode <= extOpen ? ALM_EXT : (overloadAlarm ? ALM_OVERLOAD : ALM_PROTECT);
         end
      end else if (clearEdge && alarmLatched) begin
         alarmLatched <= 1'b0;
         alarmCode <= ALM_NONE;
      end
   end

   // ---------------------------------------------------------------
   // run control
   // ---------------------------------------------------------------
   logic bothRun;
   logic stopNow;

   assign bothRun = fwdOn & revOn;
   assign stopNow = bothRun | alarmLatched | alarmSource;

   always_ff @(posedge mclk or posedge reset) begin
      if (reset) begin
         motorRun <= 1'b0;
         motorReverse <= 1'b0;
         instantStop <= 1'b0;
      end else begin
         motorRun <= (fwdOn ^ revOn) & ~stopNow;
         instantStop <= stopNow;
         if (fwdOn ^ revOn) begin
            motorReverse <= revOn;
         end
      end
   end

   always_ff @(posedge mclk or posedge reset) begin
      if (reset) begin
         holdRelease <= 1'b0;
      end else begin
         holdRelease <= holdEnable & fnLevel[FN_HOLD_FREE];
      end
   end

   always_ff @(posedge mclk or posedge reset) begin
      if (reset) begin
         activeData <= OPDATA_RST;
      end else begin
         activeData <= opSet[selSet];
      end
   end

   // ---------------------------------------------------------------
   // speed pulse output
   // ---------------------------------------------------------------
   // a tick during a pulse is dropped; ticks come far slower than 0.2 ms
   logic [$clog2(SPEED_PULSE_CYC+1)-1:0] pulseCnt;

   always_ff @(posedge mclk or posedge reset) begin
      if (reset) begin
         pulseCnt <= '0;
         speedPulseOut <= 1'b0;
      end else if (pulseCnt != '0) begin
         pulseCnt <= pulseCnt - 1'b1;
         speedPulseOut <= (pulseCnt != 1);
      end else if (rotationTick) begin
         pulseCnt <= ($clog2(SPEED_PULSE_CYC+1))'(SPEED_PULSE_CYC);
         speedPulseOut <= 1'b1;
      end
   end

   // ---------------------------------------------------------------
   // status outputs
   // ---------------------------------------------------------------
   logic [12:0] speedDiff;
   logic overloadWarn;

   assign speedDiff = (measuredSpeed >= activeData.speed) ?
      13'(measuredSpeed - activeData.speed) : 13'(activeData.speed - measuredSpeed);
   assign overloadWarn = loadFactor > overloadLevel;

   always_ff @(posedge mclk or posedge reset) begin
      if (reset) begin
         fault_indicator_out <= 1'b0;
         overload_indicator_out <= 1'b0;
      end else begin
         fault_indicator_out <= ~alarmLatched;
         overload_indicator_out <= ~(overloadWarn | overloadAlarm
            | (alarmLatched && alarmCode == ALM_OVERLOAD));
      end
   end

   always_ff @(posedge mclk or posedge reset) begin
      if (reset) begin
         runningOut <= 1'b0;
         speed_reached_out <= 1'b0;
      end else begin
         runningOut <= motorRun;
         speed_reached_out <= motorRun & (speedDiff <= {4'h0, speedBand});
      end
   end

   always_ff @(posedge mclk or posedge reset) begin
      if (reset) begin
         caution_indicator_out <= 1'b0;
      end else begin
         caution_indicator_out <= warningActive;
      end
   end

   // ---------------------------------------------------------------
   // wishbone read and acknowledge
   // ---------------------------------------------------------------
   logic [31:0] statusWord;

   always_comb begin
      statusWord = '0;
      statusWord[ST_ALARM_BIT] = alarmLatched;
      statusWord[ST_CODE_LSB +: 2] = alarmCode;
      statusWord[ST_CAUTION_BIT] = caution_indicator_out;
      statusWord[ST_RUN_BIT] = runningOut;
      statusWord[ST_REACHED_BIT] = speed_reached_out;
      statusWord[ST_OVERLOAD_BIT] = ~overload_indicator_out;
      statusWord[ST_SET_LSB +: 2] = selSet;
   end

   // one wait state; unmapped addresses answer with zero
   always_ff @(posedge mclk or posedge reset) begin
      if (reset) begin
         wb_ack_o <= 1'b0;
         wb_dat_o <= '0;
      end else begin
         wb_ack_o <= wb_cyc_i & wb_stb_i & ~wb_ack_o;
         wb_dat_o <= '0;
         case (wb_adr_i)
            REG_CTRL: wb_dat_o <= {31'h0, holdEnable};
            REG_BAND: wb_dat_o <= {23'h0, speedBand};
            REG_OVLWARN: wb_dat_o <= {23'h0, overloadLevel};
            REG_STATUS: wb_dat_o <= statusWord;
            REG_SPEED: wb_dat_o <= {20'h0, measuredSpeed};
            REG_TERMMAP: wb_dat_o <= {{(32-FN_BITS*TERMS){1'b0}}, termMap};
            default: begin
               for (int i = 0; i < OPDATA_SETS; i++) begin
                  if (wb_adr_i == REG_OPDATA0 + 8'(4 * i)) begin
                     wb_dat_o <= {4'h0, opSet[i]};
                  end
               end
            end
         endcase
      end
   end

endmodule : adio_logic
`default_nettype wire

// ===== adio_monitor.sv
// concurrent checks on the discrete i/o logic ports
`timescale 1ns/1ps
`default_nettype none
module adio_monitor
   import adio_pkg::*;
#(
   parameter int TERMS = 7,
   parameter int SPEED_PULSE_CYC = SPEED_PULSE_CYC_DEF
) (
   input wire logic mclk,
   input wire logic reset,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_ack_o,
   input wire logic [TERMS-1:0] terminalIn,
   input wire logic rotationTick,
   input wire logic overloadAlarm,
   input wire logic protectAlarm,
   input wire logic warningActive,
   input wire logic motorRun,
   input wire logic instantStop,
   input wire logic speedPulseOut,
   input wire logic fault_indicator_out,
   input wire logic overload_indicator_out,
   input wire logic runningOut,
   input wire logic speed_reached_out,
   input wire logic caution_indicator_out
);
   int highCnt;
   default clocking cb @(posedge mclk); endclocking
   default disable iff (reset);
   // --------------------------------------------------------------
   // helper: cycles the speed pulse has stood high
   // --------------------------------------------------------------
   always_ff @(posedge mclk or posedge reset) begin
      if (reset) begin
         highCnt <= 0;
      end else if (speedPulseOut) begin
         highCnt <= highCnt + 1;
      end else begin
         highCnt <= 0;
      end
   end
   // --------------------------------------------------------------
   // properties
   // --------------------------------------------------------------
   pulse_start_a: assert property (rotationTick && !speedPulseOut |=> speedPulseOut)
      else $error("speed pulse did not follow a tick");
   pulse_width_a: assert property ($fell(speedPulseOut) |-> highCnt == SPEED_PULSE_CYC)
      else $error("speed pulse width wrong");
   dual_stop_a: assert property ($past(terminalIn[0], 3) && $past(terminalIn[1], 3)
      |-> instantStop && !motorRun)
      else $error("both run inputs did not stop the motor");
   fault_open_a: assert property (protectAlarm |-> ##[1:3] !fault_indicator_out)
      else $error("fault indicator stayed closed on alarm");
   ovl_open_a: assert property (overloadAlarm |-> ##[1:3] !overload_indicator_out)
      else $error("overload indicator stayed closed on alarm");
   run_flag_a: assert property (motorRun |=> runningOut)
      else $error("running flag missing");
   caution_on_a: assert property (warningActive |-> ##[1:3] caution_indicator_out)
      else $error("caution flag missing");
   caution_off_a: assert property ($fell(warningActive) |-> ##[1:3] !caution_indicator_out)
      else $error("caution flag did not clear");
   reached_run_a: assert property (speed_reached_out |-> motorRun || $past(motorRun))
      else $error("speed reached while stopped");
   bus_ack_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
      else $error("bus request not acknowledged");
   ack_once_a: assert property (wb_ack_o |=> !wb_ack_o)
      else $error("acknowledge stood too long");
endmodule : adio_monitor
`default_nettype wire

// ===== adio_pkg.sv
// constants, types and register map of the agitator driver discrete i/o logic
`default_nettype none
package adio_pkg;

   // ---------------------------------------------------------------
   // clock and timing
   // ---------------------------------------------------------------
   localparam int CLK_HZ = 50000000;
   localparam int SPEED_PULSE_NS = 200000;
   localparam int SPEED_PULSE_CYC_DEF = SPEED_PULSE_NS / 1000 * (CLK_HZ / 1000000);
   localparam int PULSES_PER_REV = 30;

   // ---------------------------------------------------------------
   // register byte offsets
   // ---------------------------------------------------------------
   localparam logic [7:0] REG_CTRL = 8'h00;
   localparam logic [7:0] REG_BAND = 8'h04;
   localparam logic [7:0] REG_OVLWARN = 8'h08;
   localparam logic [7:0] REG_STATUS = 8'h0c;
   localparam logic [7:0] REG_SPEED = 8'h10;
   localparam logic [7:0] REG_TERMMAP = 8'h14;
   localparam logic [7:0] REG_OPDATA0 = 8'h20;

   // ---------------------------------------------------------------
   // field layout and reset values
   // ---------------------------------------------------------------
   localparam int CTRL_HOLD_EN_BIT = 0;
   localparam logic [8:0] BAND_MAX = 9'h190;
   localparam logic [8:0] BAND_RST = 9'h0c8;
   localparam logic [8:0] OVLWARN_RST = 9'h078;
   localparam logic [11:0] OPSPEED_RST = 12'h032;
   localparam logic [7:0] OPRAMP_RST = 8'h05;
   localparam int OPDATA_SETS = 4;
   localparam int ST_ALARM_BIT = 0;
   localparam int ST_CODE_LSB = 1;
   localparam int ST_CAUTION_BIT = 3;
   localparam int ST_RUN_BIT = 4;
   localparam int ST_REACHED_BIT = 5;
   localparam int ST_OVERLOAD_BIT = 6;
   localparam int ST_SET_LSB = 7;
   localparam int FN_BITS = 3;

   // ---------------------------------------------------------------
   // input terminal functions and alarm codes
   // ---------------------------------------------------------------
   typedef enum logic [2:0] {
      FN_NONE = 3'h0,
      FN_FWD = 3'h1,
      FN_REV = 3'h2,
      FN_SEL_LOW = 3'h3,
      FN_SEL_HIGH = 3'h4,
      FN_CLEAR = 3'h5,
      FN_EXT_FAULT = 3'h6,
      FN_HOLD_FREE = 3'h7
   } adio_func_e;

   localparam logic [20:0] TERMMAP_RST = {3'h7, 3'h6, 3'h5, 3'h4, 3'h3, 3'h2, 3'h1};

   typedef enum logic [1:0] {
      ALM_NONE = 2'h0,
      ALM_EXT = 2'h1,
      ALM_OVERLOAD = 2'h2,
      ALM_PROTECT = 2'h3
   } adio_alarm_e;

   // one operation data set: r/min, ramps in 0.1 s
   typedef struct packed {
      logic [7:0] decel;
      logic [7:0] accel;
      logic [11:0] speed;
   } adio_opdata_s;

   localparam adio_opdata_s OPDATA_RST = '{decel: OPRAMP_RST, accel: OPRAMP_RST,
      speed: OPSPEED_RST};

endpackage : adio_pkg
`default_nettype wire

// ===== testbench.sv
// self-checking bench of the discrete i/o logic
`timescale 1ns/1ps
`default_nettype none
module testbench;
   import adio_pkg::*;
   localparam int PW = 20;
   typedef struct packed {
      logic [6:0] t;
      logic run;
      logic stop;
      logic reverse_run_in;
      logic [1:0] set;
   } adio_row_s;
   logic mclk = 0, reset = 1, wbCyc = 0, wbStb = 0, wbWe = 0, wbAck, rotationTick = 0;
   logic [7:0] wbAdr = 0;
   logic [31:0] wbDatW = 0, wbDatR, rd;
   // external fault contact closed from the start, so release of reset is healthy
   logic [6:0] terms = 7'h20;
   logic [11:0] measuredSpeed = 0;
   logic [8:0] loadFactor = 0;
   logic [1:0] alarms = 0;
   logic warningActive = 0, motorRun, motorReverse, instantStop, holdRelease, speedPulseOut;
   logic faultInd, ovlInd, runningOut, reached, caution;
   adio_opdata_s activeData;
   int bad_count = 0, n_compared = 0, rpm, width;
   adio_row_s rows [7] = '{{7'h20, 3'b000, 2'd0}, {7'h21, 3'b100, 2'd0}, {7'h22, 3'b101, 2'd0},
      {7'h23, 3'b010, 2'd0}, {7'h25, 3'b100, 2'd1}, {7'h29, 3'b100, 2'd2}, {7'h2d, 3'b100, 2'd3}};
   adio_logic #(.SPEED_PULSE_CYC(PW)) i_dut (.mclk, .reset, .wb_cyc_i(wbCyc), .wb_stb_i(wbStb),
      .wb_we_i(wbWe), .wb_adr_i(wbAdr), .wb_sel_i(4'hf), .wb_dat_i(wbDatW), .wb_dat_o(wbDatR),
      .wb_ack_o(wbAck), .terminalIn(terms), .rotationTick, .measuredSpeed, .loadFactor,
      .overloadAlarm(alarms[0]), .protectAlarm(alarms[1]), .warningActive, .motorRun,
      .motorReverse, .instantStop, .holdRelease, .activeData, .speedPulseOut,
      .fault_indicator_out(faultInd), .overload_indicator_out(ovlInd), .runningOut,
      .speed_reached_out(reached), .caution_indicator_out(caution));
   adio_ctrl_model i_ctrl (.mclk, .reset, .speedPulseOut, .rpm, .width);
   initial begin
      forever #10 mclk = ~mclk;
   end
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      n_compared++;
      if (seen !== exp) begin
         bad_count++;
         $display("[ERR] t=%0t seen=%h expected=%h", $time, seen, exp);
      end
   endtask : check
   task automatic wb(input logic we, input logic [7:0] adr, input logic [31:0] dat);
      int guard;
      guard = 0;
      @(posedge mclk);
      wbCyc <= 1'b1;
      wbStb <= 1'b1;
      wbWe <= we;
      wbAdr <= adr;
      wbDatW <= dat;
      do begin
         @(posedge mclk);
         guard++;
      end while (wbAck !== 1'b1 && guard < 50);
      // ack and read data are taken at the very edge that samples them
      rd = wbDatR;
      wbCyc <= 1'b0;
      wbStb <= 1'b0;
      if (wbAck !== 1'b1) begin
         bad_count++;
      end
   endtask : wb
   // pins pass two sync stages plus a register; six cycles covers the indicators
   task automatic term(input logic [6:0] v);
      @(posedge mclk);
      terms <= v;
      repeat (6) @(negedge mclk);
   endtask : term
   task automatic end_of_test;
      $display("compared %0d mismatches %0d", n_compared, bad_count);
      if (bad_count == 0 && n_compared > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask : end_of_test
   initial begin
      repeat (60000) @(posedge mclk);
      bad_count++;
      end_of_test();
   end
   initial begin
      repeat (12) @(posedge mclk);
      reset <= 1'b0;
      term(7'h20);
      check(faultInd, 1'b1);
      check(ovlInd, 1'b1);
      wb(1'b0, REG_BAND, 0);
      check(rd, 32'(BAND_RST));
      wb(1'b0, REG_OVLWARN, 0);
      check(rd, 32'(OVLWARN_RST));
      wb(1'b0, 8'h3c, 0);
      check(rd, 32'h0);
      wb(1'b1, REG_BAND, 32'h1f4);
      wb(1'b0, REG_BAND, 0);
      check(rd, 32'(BAND_MAX));
      wb(1'b1, REG_BAND, 32'(BAND_RST));
      for (int k = 0; k < OPDATA_SETS; k++) begin
         wb(1'b1, REG_OPDATA0 + 8'(4 * k), {4'h0, OPRAMP_RST, OPRAMP_RST, 12'(100 + k)});
      end
      wb(1'b0, REG_OPDATA0 + 8'h04, 0);
      check(rd, {4'h0, OPRAMP_RST, OPRAMP_RST, 12'h065});
      foreach (rows[i]) begin
         term(rows[i].t);
         check(motorRun, rows[i].run);
         check(instantStop, rows[i].stop);
         check(runningOut, rows[i].run);
         check(activeData.speed, 12'(100 + rows[i].set));
         if (rows[i].run) check(motorReverse, rows[i].reverse_run_in);
      end
      term(7'h21);
      @(posedge mclk);
      measuredSpeed <= 12'd300;
      repeat (4) @(negedge mclk);
      check(reached, 1'b1);
      @(posedge mclk);
      measuredSpeed <= 12'd301;
      repeat (4) @(negedge mclk);
      check(reached, 1'b0);
      @(posedge mclk);
      warningActive <= 1'b1;
      repeat (4) @(negedge mclk);
      check({caution, motorRun}, 2'b11);
      @(posedge mclk);
      warningActive <= 1'b0;
      repeat (4) @(negedge mclk);
      check(caution, 1'b0);
      @(posedge mclk);
      loadFactor <= 9'd121;
      repeat (4) @(negedge mclk);
      check(ovlInd, 1'b0);
      @(posedge mclk);
      loadFactor <= 9'd120;
      repeat (4) @(negedge mclk);
      check(ovlInd, 1'b1);
      for (int k = 0; k < 2; k++) begin
         @(posedge mclk);
         alarms <= 2'(1 << k);
         repeat (4) @(negedge mclk);
         check({faultInd, motorRun}, 2'b00);
         if (k == 0) check(ovlInd, 1'b0);
         @(posedge mclk);
         alarms <= 2'b00;
         term(7'h31);
         term(7'h21);
         check({faultInd, motorRun}, 2'b11);
      end
      term(7'h01);
      check({faultInd, instantStop, motorRun}, 3'b010);
      term(7'h31);
      term(7'h21);
      check(faultInd, 1'b1);
      wb(1'b1, REG_CTRL, 32'h1);
      term(7'h60);
      check(holdRelease, 1'b1);
      wb(1'b1, REG_CTRL, 32'h0);
      repeat (4) @(negedge mclk);
      check(holdRelease, 1'b0);
      wb(1'b1, REG_TERMMAP, 32'({3'h1, TERMMAP_RST[17:0]}));
      term(7'h60);
      check(motorRun, 1'b1);
      wb(1'b1, REG_TERMMAP, 32'(TERMMAP_RST));
      term(7'h21);
      // second tick lands inside the pulse and must be ignored
      repeat (4) begin
         @(posedge mclk);
         rotationTick <= 1'b1;
         @(posedge mclk);
         rotationTick <= 1'b0;
         repeat (4) @(posedge mclk);
         rotationTick <= 1'b1;
         @(posedge mclk);
         rotationTick <= 1'b0;
         repeat (1993) @(posedge mclk);
      end
      check(rpm, 32'(longint'(CLK_HZ) * 2 / 2000));
      check(width, PW);
      end_of_test();
   end
endmodule : testbench
bind adio_logic adio_monitor #(.TERMS(TERMS), .SPEED_PULSE_CYC(SPEED_PULSE_CYC)) i_mon (.mclk,
   .reset, .wb_cyc_i, .wb_stb_i, .wb_ack_o, .terminalIn, .rotationTick, .overloadAlarm,
   .protectAlarm, .warningActive, .motorRun, .instantStop, .speedPulseOut, .fault_indicator_out,
   .overload_indicator_out, .runningOut, .speed_reached_out, .caution_indicator_out);
`default_nettype wire
